// File: rtl/rtabr_pkg.sv
// Package: register indices, field positions, reset values and timing counts
// for the terminal address / self-test / reset / time-tag register bank.
// Assumes a 200 MHz pclk and a 32-bit APB slave with one word per register.
package rtabr_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [3:0] IDX_ADDR_CTRL = 4'hA;
  localparam logic [3:0] IDX_SELF_TEST = 4'hB;
  localparam logic [3:0] IDX_PROG_RESET = 4'hC;
  localparam logic [3:0] IDX_TAG_CLEAR = 4'hD;
  localparam logic [3:0] IDX_TEST_STATUS = 4'hE;
  localparam logic [3:0] IDX_TEST_RESULT = 4'hF;

  // ****************************************************************
  // Field positions of the address/control register
  // ****************************************************************
  localparam int POS_INSTR = 15;
  localparam int POS_SOFT_BUSY = 14;
  localparam int POS_SUBSYS_FAIL = 13;
  localparam int POS_DBC_ACCEPT = 12;
  localparam int POS_TERM_FLAG = 11;
  localparam int POS_SERV_REQ = 10;
  localparam int POS_FORCED_BUSY = 9;
  localparam int POS_MODE_SEL = 8;
  localparam int POS_LOCKOUT = 7;
  localparam int POS_PAR_ERR = 6;
  localparam int POS_ADDR_PAR = 5;
  localparam int POS_ADDR_MSB = 4;

  // Self-test result word and status bits
  localparam int POS_FAIL_A = 14;
  localparam int POS_FAIL_B = 15;
  localparam int POS_TEST_BUSY = 0;
  localparam int POS_TEST_DONE = 1;

  // Reset value of the status flag bits 15..9
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int SELF_TEST_US = 100;
  localparam int SELF_TEST_CYCLES = SELF_TEST_US * CLK_MHZ;
  localparam int PROG_RESET_US = 1;
  // Held well inside the sub-microsecond bound
  localparam int PROG_RESET_CYCLES = (PROG_RESET_US * CLK_MHZ) / 2;
  localparam int TAG_TICK_US = 64;
  localparam int TAG_TICK_CYCLES = TAG_TICK_US * CLK_MHZ;
  localparam int TAG_WIDTH = 8;

endpackage

// File: rtl/rtabr_tick_div.sv
// Divider that emits a one-cycle enable pulse every PERIOD cycles.
// Assumes a single clock; clear restarts the count from zero.
`timescale 1ns/1ps
module rtabr_tick_div #(
  parameter int PERIOD = 12800
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  output logic tick
);

  logic [31:0] count;
  wire last = (count == 32'(PERIOD - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h0;
    end else if (clear || last) begin
      count <= 32'h0;
    end else begin
      count <= count + 32'h1;
    end
  end

  assign tick = last && !clear;

endmodule // rtabr_tick_div

// File: rtl/rtabr_countdown.sv
// Load-and-run down counter; busy while nonzero, done pulses at expiry.
// Assumes a single clock and a load that may restart a running count.
`timescale 1ns/1ps
module rtabr_countdown #(
  parameter int CYCLES = 20000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  output logic busy,
  output logic done
);

  logic [31:0] remain;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= 32'h0;
    end else if (load) begin
      remain <= 32'(CYCLES);
    end else if (remain != 32'h0) begin
      remain <= remain - 32'h1;
    end
  end

  assign busy = (remain != 32'h0);
  assign done = (remain == 32'h1) && !load;

endmodule // rtabr_countdown

// File: rtl/rtabr_regs.sv
// Terminal address, status flag, self-test, programmed reset and time-tag
// register bank with an APB slave. Assumes synchronous pin inputs on pclk
// and a protocol engine that consumes the status flags and strobes.
//
// What this block does
// - Instrumentation control bit sets status word instrumentation bit.
// - Soft busy bit sets status busy; transfers continue.
// - Subsystem fail bit sets status flag and, in terminal mode, logs in message status.
// - Acceptance bit reports bus control acceptance on mode code; host takes over.
// - Terminal flag from control bit or from a failed self-test.
// - Service request bit sets status word service request bit.
// - Forced busy sets status busy and blocks subsystem transfers.
// - Mode-select bit reads the controller/terminal select pin level.
// - Lockout bit mirrors lockout pin; writes ignored.
// - Lockout blocks host changes to the address; the mode-select bit follows its pin regardless.
// - Address parity checked after latch; error bit set on failure.
// - Parity bit makes address plus parity odd; supplied by host or pins.
// - Address loads from pins at master reset; writes replace it.
// - Any self-test write launches a 100 us test; busy bit shows it.
// - Self-test loops encoder to decoders; A fail bit 14, B bit 15.
// - In terminal mode, bus commands ignored during self-test.
// - Programmed reset resets codec and protocol under 1 us; registers kept.
// - Programmed reset like reset-terminal mode code, but processing halts.
// - Timer reset write clears time tag; counting resumes at once.
// - Eight-bit free-running time tag increments every 64 us.
// - Status option input decides if flag bits affect status words.
// - Self-test completion raises high-priority interrupt when enabled.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module rtabr_regs #(
  parameter int SELF_TEST_CYCLES = rtabr_pkg::SELF_TEST_CYCLES,
  parameter int TAG_TICK_CYCLES = rtabr_pkg::TAG_TICK_CYCLES,
  parameter int PROG_RESET_CYCLES = rtabr_pkg::PROG_RESET_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [4:0] terminal_address_inputs,
  input wire logic terminal_address_parity_input,
  input wire logic controller_terminal_select_pin,
  input wire logic lockout_pin,
  input wire logic status_option_mode_input,
  input wire logic controller_mode_active,
  input wire logic end_of_test_enable,
  // Self-test loopback results from the decoders
  input wire logic loop_fail_a,
  input wire logic loop_fail_b,
  // Status word flags to the protocol engine
  output logic status_instrumentation,
  output logic status_busy,
  output logic status_subsystem_flag,
  output logic status_bus_control_accept,
  output logic status_terminal_flag,
  output logic status_service_request,
  output logic message_subsystem_fail,
  output logic subsystem_transfer_inhibit,
  output logic [4:0] terminal_address,
  output logic terminal_address_parity_error,
  output logic self_test_running,
  output logic self_test_loopback,
  output logic ignore_bus_commands,
  output logic codec_protocol_reset,
  output logic command_processing_halt,
  output logic end_of_test_irq,
  output logic [7:0] time_tag
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire access = psel && penable;
  wire [5:0] word_idx = paddr[7:2];
  wire wr = access && pwrite;
  wire sel_ctrl = (word_idx == {2'h0, rtabr_pkg::IDX_ADDR_CTRL});
  wire sel_test = (word_idx == {2'h0, rtabr_pkg::IDX_SELF_TEST});
  wire sel_prst = (word_idx == {2'h0, rtabr_pkg::IDX_PROG_RESET});
  wire sel_tclr = (word_idx == {2'h0, rtabr_pkg::IDX_TAG_CLEAR});
  wire sel_stat = (word_idx == {2'h0, rtabr_pkg::IDX_TEST_STATUS});
  wire sel_res = (word_idx == {2'h0, rtabr_pkg::IDX_TEST_RESULT});
  wire mapped = sel_ctrl | sel_test | sel_prst | sel_tclr | sel_stat | sel_res;

  wire wr_ctrl = wr && sel_ctrl;
  wire start_test = wr && sel_test;
  wire start_prst = wr && sel_prst;
  wire clear_tag = wr && sel_tclr;

  // Every register answers at once, so the slave never inserts wait states
  assign pready = 1'b1;
  // Unmapped accesses are flagged but otherwise change nothing
  assign pslverr = access && !mapped;

  // ****************************************************************
  // Address/control register
  // ****************************************************************
  logic [6:0] flags;
  logic [4:0] addr_q;
  logic addr_par_q;
  logic par_err;
  logic par_check;
  logic strap_pending;

  // Lockout freezes the address; the flag bits stay writable
  wire addr_write = wr_ctrl && !lockout_pin;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= rtabr_pkg::FLAGS_RESET;
    end else if (wr_ctrl) begin
      flags <= pwdata[rtabr_pkg::POS_INSTR:rtabr_pkg::POS_FORCED_BUSY];
    end
  end

  // Pins are caught one clock after reset release, never under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_pending <= 1'b1;
      addr_q <= 5'h00;
      addr_par_q <= 1'b0;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      addr_q <= terminal_address_inputs;
      addr_par_q <= terminal_address_parity_input;
    end else if (addr_write) begin
      addr_q <= pwdata[rtabr_pkg::POS_ADDR_MSB:0];
      addr_par_q <= pwdata[rtabr_pkg::POS_ADDR_PAR];
    end
  end

  // Parity is judged the cycle after each latch
  // Under lockout the address cannot move, so the last verdict stays valid
  wire odd_ok = ^{addr_q, addr_par_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_check <= 1'b0;
      par_err <= 1'b0;
    end else begin
      par_check <= strap_pending || addr_write;
      if (par_check) begin
        par_err <= !odd_ok;
      end
    end
  end

  // ****************************************************************
  // Self-test
  // ****************************************************************
  logic test_done;
  logic test_done_flag;
  logic [1:0] fail_ab;

  rtabr_countdown #(
    .CYCLES(SELF_TEST_CYCLES)
  ) u_test_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(start_test),
    .busy(self_test_running),
    .done(test_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_ab <= 2'h0;
      test_done_flag <= 1'b0;
    end else if (start_test) begin
      fail_ab <= 2'h0;
      test_done_flag <= 1'b0;
    end else if (self_test_running) begin
      // Failures accumulate over the whole run; a one-cycle glitch still counts
      fail_ab <= fail_ab | {loop_fail_b, loop_fail_a};
      test_done_flag <= test_done;
    end
  end

  assign self_test_loopback = self_test_running;
  assign ignore_bus_commands = self_test_running && !controller_mode_active;
  // Registered so an edge-triggered interrupt controller sees a clean pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      end_of_test_irq <= 1'b0;
    end else begin
      end_of_test_irq <= test_done && end_of_test_enable;
    end
  end
  wire test_failed = test_done_flag && (fail_ab != 2'h0);

  // ****************************************************************
  // Programmed reset
  // ****************************************************************
  logic halt_q;

  rtabr_countdown #(
    .CYCLES(PROG_RESET_CYCLES)
  ) u_prst_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(start_prst),
    .busy(codec_protocol_reset),
    .done()
  );

  // Processing stays halted until the host starts a self-test or resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= 1'b0;
    end else if (start_prst) begin
      halt_q <= 1'b1;
    end else if (start_test) begin
      halt_q <= 1'b0;
    end
  end
  assign command_processing_halt = halt_q;

  // ****************************************************************
  // Time tag
  // ****************************************************************
  logic tag_tick;
  logic [rtabr_pkg::TAG_WIDTH-1:0] tag_q;

  // A clear restarts the prescaler too, so the first step after it is a full period
  rtabr_tick_div #(
    .PERIOD(TAG_TICK_CYCLES)
  ) u_tag_div (
    .pclk(pclk),
    .presetn(presetn),
    .clear(clear_tag),
    .tick(tag_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_q <= 8'h00;
    end else if (clear_tag) begin
      tag_q <= 8'h00;
    end else if (tag_tick) begin
      tag_q <= tag_q + 8'h01;
    end
  end
  assign time_tag = tag_q;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // With the option input low the software flags do not reach the status word
  wire opt = status_option_mode_input;
  logic test_fail_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_fail_seen <= 1'b0;
    end else if (start_test) begin
      test_fail_seen <= 1'b0;
    end else if (test_failed) begin
      test_fail_seen <= 1'b1;
    end
  end

  // Option gate per flag bit; the self-test terminal flag bypasses it
  logic [6:0] flag_gated;
  for (genvar g = 0; g < 7; g++) begin : g_flag_gate
    assign flag_gated[g] = opt && flags[g];
  end

  wire f_instr = flag_gated[rtabr_pkg::POS_INSTR - 9];
  wire f_sbusy = flag_gated[rtabr_pkg::POS_SOFT_BUSY - 9];
  wire f_ssf = flag_gated[rtabr_pkg::POS_SUBSYS_FAIL - 9];
  wire f_dbca = flag_gated[rtabr_pkg::POS_DBC_ACCEPT - 9];
  wire f_tf = flag_gated[rtabr_pkg::POS_TERM_FLAG - 9];
  wire f_sr = flag_gated[rtabr_pkg::POS_SERV_REQ - 9];
  wire f_fbusy = flag_gated[rtabr_pkg::POS_FORCED_BUSY - 9];

  wire next_instr = f_instr;
  wire next_busy = f_sbusy || f_fbusy;
  wire next_ssf = f_ssf;
  wire next_msg_ssf = f_ssf && !controller_mode_active;
  wire next_dbca = f_dbca;
  wire next_tf = f_tf || test_fail_seen;
  wire next_sr = f_sr;
  wire next_inhibit = f_fbusy;

  // ****************************************************************
  // Status word outputs
  // ****************************************************************
  // Registered so the protocol engine never samples a half-updated flag set;
  // flags therefore reach the status word one clock after the write lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_instrumentation <= 1'b0;
      status_busy <= 1'b0;
      status_subsystem_flag <= 1'b0;
      message_subsystem_fail <= 1'b0;
      status_bus_control_accept <= 1'b0;
      status_terminal_flag <= 1'b0;
      status_service_request <= 1'b0;
      subsystem_transfer_inhibit <= 1'b0;
    end else begin
      status_instrumentation <= next_instr;
      status_busy <= next_busy;
      status_subsystem_flag <= next_ssf;
      message_subsystem_fail <= next_msg_ssf;
      status_bus_control_accept <= next_dbca;
      status_terminal_flag <= next_tf;
      status_service_request <= next_sr;
      subsystem_transfer_inhibit <= next_inhibit;
    end
  end
  assign terminal_address = addr_q;
  assign terminal_address_parity_error = par_err;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Read-only bits come from pins and logic, so writes cannot reach them
  wire [15:0] ctrl_rd = {flags,
                         controller_terminal_select_pin,
                         lockout_pin,
                         par_err,
                         addr_par_q,
                         addr_q};
  wire [15:0] res_rd = {fail_ab[1], fail_ab[0], 14'h0000};
  wire [15:0] stat_rd = {14'h0000, test_done_flag, self_test_running};
  // Strobe registers read zero
  wire [15:0] rd_sel = sel_ctrl ? ctrl_rd :
                       sel_res ? res_rd :
                       sel_stat ? stat_rd : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd_sel};
    end
  end

endmodule // rtabr_regs

// File: bench/rtabr_regs_props.sv
// Checker: concurrent properties on the register bank's top-level ports.
// Assumes PROG_RESET_CYCLES of 4 and a self-test of at least 8 cycles.
`timescale 1ns/1ps
module rtabr_regs_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic lockout_pin,
  input wire logic status_option_mode_input,
  input wire logic controller_mode_active,
  input wire logic status_instrumentation,
  input wire logic status_busy,
  input wire logic status_service_request,
  input wire logic subsystem_transfer_inhibit,
  input wire logic [4:0] terminal_address,
  input wire logic self_test_running,
  input wire logic ignore_bus_commands,
  input wire logic codec_protocol_reset,
  input wire logic command_processing_halt,
  input wire logic end_of_test_irq,
  input wire logic [7:0] time_tag
);
  // ****
  // Write decode
  // ****
  wire logic wr_any = psel && penable && pwrite;
  wire logic wr_ctrl = wr_any && paddr == 8'h28;
  wire logic wr_test = wr_any && paddr == 8'h2C;
  wire logic wr_prst = wr_any && paddr == 8'h30;
  wire logic wr_tclr = wr_any && paddr == 8'h34;
  wire logic opt = status_option_mode_input;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // Properties
  // ****
  chk_instr_write: assert property (wr_ctrl |=> ##1 !$past(opt)
    || status_instrumentation == $past(pwdata[15], 2))
    else $error("instrumentation flag wrong");
  chk_soft_busy: assert property (wr_ctrl && pwdata[14] && !pwdata[9]
    |=> ##1 !$past(opt) || (status_busy && !subsystem_transfer_inhibit))
    else $error("soft busy wrong");
  chk_serv_req: assert property (wr_ctrl |=> ##1 !$past(opt)
    || status_service_request == $past(pwdata[10], 2))
    else $error("service request wrong");
  chk_forced_busy: assert property (wr_ctrl && pwdata[9]
    |=> ##1 !$past(opt) || (status_busy && subsystem_transfer_inhibit))
    else $error("forced busy wrong");
  chk_lock_hold: assert property (wr_ctrl && lockout_pin |=> $stable(terminal_address))
    else $error("address changed under lockout");
  chk_addr_write: assert property (wr_ctrl && !lockout_pin
    |=> terminal_address == $past(pwdata[4:0]))
    else $error("address not written");
  chk_test_run: assert property (wr_test |=> self_test_running [*8])
    else $error("self-test not running");
  chk_test_quiet: assert property (self_test_running && !controller_mode_active
    |-> ignore_bus_commands)
    else $error("commands not ignored");
  chk_prst_len: assert property (wr_prst |=> codec_protocol_reset [*4] ##1 !codec_protocol_reset)
    else $error("codec reset length wrong");
  chk_prst_halt: assert property (wr_prst |=> command_processing_halt)
    else $error("processing not halted");
  chk_tag_clear: assert property (wr_tclr |=> time_tag == 8'h00)
    else $error("time tag not cleared");
  chk_tag_step: assert property ($changed(time_tag) && !$past(wr_tclr)
    |-> time_tag == 8'($past(time_tag) + 8'h01))
    else $error("time tag step wrong");
  chk_opt_mask: assert property (!$past(opt)
    |-> !status_instrumentation && !status_service_request)
    else $error("flags not masked");
  cover property (wr_test);
  cover property (wr_prst);
  cover property (end_of_test_irq);
endmodule // rtabr_regs_props

// File: bench/rtabr_apb_host.sv
// Host model: APB master that issues one transfer per xfer call.
// Assumes xfer is entered right after a rising pclk edge.
`timescale 1ns/1ps
module rtabr_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    hung = 1'b0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdat, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung = (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle bus carries inverted values so stale address or data cannot look valid
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // rtabr_apb_host

// File: bench/testbench.sv
// Self-checking bench: register traffic, strobes and timers of the bank.
// Assumes shortened timing parameters and the host model for APB.
`timescale 1ns/1ps
module testbench;
  localparam int TEST_CYC = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, hung, err;
  logic [7:0] paddr, time_tag;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] terminal_address_inputs = 5'h13, terminal_address;
  logic terminal_address_parity_input = 1'b0, controller_terminal_select_pin = 1'b1;
  logic lockout_pin = 1'b0, status_option_mode_input = 1'b1, controller_mode_active = 1'b0;
  logic end_of_test_enable = 1'b1, loop_fail_a = 1'b0, loop_fail_b = 1'b0;
  logic status_instrumentation, status_busy, status_subsystem_flag, status_bus_control_accept;
  logic status_terminal_flag, status_service_request, message_subsystem_fail;
  logic subsystem_transfer_inhibit, terminal_address_parity_error, self_test_running;
  logic self_test_loopback, ignore_bus_commands, codec_protocol_reset, command_processing_halt;
  logic end_of_test_irq;
  logic [31:0] wq[$];
  int fail_count = 0, samples_checked = 0, flags = 0, addr = 5'h13, par = 0, n;
  rtabr_regs #(.SELF_TEST_CYCLES(TEST_CYC), .TAG_TICK_CYCLES(8), .PROG_RESET_CYCLES(4)) dut (.*);
  rtabr_apb_host host (.*);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // ****
  // Checking and bus tasks
  // ****
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [3:0] idx, input logic [31:0] d);
    host.xfer(w, {2'h0, idx, 2'h0}, d, rd, err);
    if (hung) begin
      fail_count++;
      results();
    end
  endtask
  function automatic logic [31:0] ctrl_exp();
    return {16'h0, flags[6:0], controller_terminal_select_pin, lockout_pin,
            ~^{par[0], addr[4:0]}, par[0], addr[4:0]};
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(86320));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    cmp("address", 32'(addr), 32'(terminal_address));
    cmp("parity error", 0, 32'(terminal_address_parity_error));
    for (int i = 0; i < 10; i++) wq.push_back($urandom());
    foreach (wq[i]) begin
      lockout_pin <= wq[i][20];
      controller_terminal_select_pin <= wq[i][21];
      @(posedge pclk);
      acc(1'b1, rtabr_pkg::IDX_ADDR_CTRL, wq[i]);
      flags = int'(wq[i][15:9]);
      if (!lockout_pin) begin
        addr = int'(wq[i][4:0]);
        par = int'(wq[i][5]);
      end
      @(posedge pclk);
      acc(1'b0, rtabr_pkg::IDX_ADDR_CTRL, 0);
      cmp("ctrl", ctrl_exp(), rd);
      cmp("flags", 32'({flags[6], flags[5] | flags[0], flags[4], flags[2], flags[1], flags[0]}),
          32'({status_instrumentation, status_busy, status_subsystem_flag, status_terminal_flag,
               status_service_request, subsystem_transfer_inhibit}));
    end
    status_option_mode_input <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    cmp("masked", 0, 32'({status_instrumentation, status_service_request}));
    status_option_mode_input <= 1'b1;
    acc(1'b0, 4'h3, 0);
    cmp("unmapped", 32'h1, {rd[30:0], err});
    acc(1'b0, rtabr_pkg::IDX_PROG_RESET, 0);
    cmp("strobe read", 0, {rd[31:1], codec_protocol_reset});
    acc(1'b1, rtabr_pkg::IDX_PROG_RESET, 32'h0000FFFF);
    cmp("prog reset", 3, 32'({codec_protocol_reset, command_processing_halt}));
    repeat (5) @(posedge pclk);
    cmp("prog reset end", 0, 32'(codec_protocol_reset));
    acc(1'b0, rtabr_pkg::IDX_ADDR_CTRL, 0);
    cmp("ctrl kept", ctrl_exp(), rd);
    loop_fail_b <= 1'b1;
    acc(1'b1, rtabr_pkg::IDX_SELF_TEST, $urandom());
    cmp("test start", 6, 32'({self_test_running, ignore_bus_commands, command_processing_halt}));
    n = 0;
    while (end_of_test_irq !== 1'b1 && n < 2 * TEST_CYC) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2 * TEST_CYC) begin
      fail_count++;
      results();
    end
    repeat (3) @(posedge pclk);
    acc(1'b0, rtabr_pkg::IDX_TEST_RESULT, 0);
    cmp("test result", 32'h00008000, rd);
    acc(1'b0, rtabr_pkg::IDX_TEST_STATUS, 0);
    cmp("test status", 32'h00000002, rd);
    cmp("terminal flag", 1, 32'(status_terminal_flag));
    acc(1'b1, rtabr_pkg::IDX_TAG_CLEAR, $urandom());
    cmp("tag clear", 0, 32'(time_tag));
    repeat (27) @(posedge pclk);
    cmp("tag run", 3, 32'(time_tag));
    results();
  end
endmodule // testbench
bind rtabr_regs rtabr_regs_props props (.*);
